// *** hw/file_register_instr_decoder.sv ***
/*
  Decoder and sequencer for byte- and bit-oriented file-register instructions.
  Assumes one word is presented per instruction cycle, with its operands, at the
  last phase of that cycle; all inputs are synchronous to REF_CLK.
*/
// How it works
// - Add, add-with-carry, increment, decrement: one cycle, all five flags.
// - And, or, complement, exclusive or: one cycle, zero and negative only.
// - Negate all flags; clear zero only; set, store, multiply no flags.
// - The three subtractions decode as given, one cycle, all five flags.
// - Rotate left through carry: C,Z,N; plain rotates: Z,N only.
// - Rotate right through carry: one cycle, C,Z,N, bits pass through carry.
// - Two-word move: source then destination word, two cycles, no flags.
// - Two-word move forces top two address bits of both addresses to zero.
// - Three-word long move carries full addresses, three cycles, no flags.
// - Compare-and-skip equal, greater, less: one cycle, more when skipping.
// - Decrement or test, skip if zero; extra cycles when skipping, no flags.
// - Increment/decrement skip variants write result and skip on condition.
// - Bit clear, set, toggle, skip-if-clear use 3-bit number; no flags.
// - Skip-if-set skips the next word when the chosen bit is one.
// - A taken skip costs one extra no-operation cycle per word of the skipped instruction.
// - Trailing words reached on their own decode as no-operations.
// - Destination bit clear sends result to working register, set to file.
// - One instruction cycle lasts four clock periods.
// - Trailing words start with ones and so run as no-operations.
`timescale 1ns/1ps
module file_register_instr_decoder import decode_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Fetched word and operands
  input wire logic [15:0] INSTR_WORD,
  input wire logic [7:0] FILE_DATA,
  input wire logic [7:0] WORK_DATA,
  input wire logic CARRY_IN,
  input wire logic [5:0] BANK_SEL,
  // Cycle timing
  output logic CYCLE_STROBE,
  // Decoded operation
  output op_t OP,
  output logic [ADDR_W-1:0] FILE_ADDR,
  output logic DEST_TO_FILE,
  output logic [2:0] BIT_NUM,
  output logic [4:0] FLAG_MASK,
  output logic [7:0] RESULT,
  // File-to-file moves
  output logic [ADDR_W-1:0] SRC_ADDR,
  output logic [ADDR_W-1:0] DST_ADDR,
  output logic MOVE_VALID,
  // Execution control
  output logic EXEC_NOP,
  output logic SKIP_TAKEN,
  output logic INSTR_DONE,
  output logic [2:0] INSTR_CYCLES
);

  ////////////////////////////////////////////////////////////////////////////////
  // Phase counter
  logic [1:0] phase;
  st_t state;
  logic [1:0] tail;
  logic [2:0] cyc;

  wire boundary = phase == PHASE_LAST;
  wire [1:0] next_phase = phase + 2'h1;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      phase <= 2'h0;
      CYCLE_STROBE <= 1'b0;
    end else begin
      phase <= next_phase;
      CYCLE_STROBE <= boundary;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First-word decode
  wire op_t dec_op = decode_op(INSTR_WORD);
  wire [7:0] f_field = INSTR_WORD[7:0];
  wire a_bit = INSTR_WORD[ACCESS_BIT];
  wire d_bit = INSTR_WORD[DEST_BIT];
  wire [2:0] b_field = INSTR_WORD[BITNUM_LSB+2:BITNUM_LSB];
  wire [7:0] unit_result;
  wire unit_skip;

  operand_unit u_operand (
    .op(dec_op),
    .bit_num(b_field),
    .file_data(FILE_DATA),
    .work_data(WORK_DATA),
    .carry_in(CARRY_IN),
    .result(unit_result),
    .take_skip(unit_skip)
  );

  // Access region below the split maps to the low bank, above it to the top bank
  wire [5:0] access_bank = (f_field < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
  wire [5:0] sel_bank = a_bit ? BANK_SEL : access_bank;

  // Result steering
  wire dec_dest = has_dest(dec_op) ? d_bit : writes_file(dec_op);

  // Words that bring trailing words with them
  wire two_word_first = (INSTR_WORD[15:12] == 4'hc) || (INSTR_WORD[15:10] == 6'h3b);
  wire three_word_first = INSTR_WORD[15:4] == LONG_MOVE_HEAD;
  wire [1:0] skipped_tail = three_word_first ? 2'h2 : (two_word_first ? 2'h1 : 2'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire in_decode = state == ST_DECODE;
  wire in_skip = (state == ST_SKIP) || (state == ST_SKIP_TAIL);
  wire take_skip = in_decode && unit_skip;

  st_t next_state;
  logic [1:0] next_tail;

  always_comb begin
    next_state = state;
    next_tail = tail;
    case (state)
      ST_DECODE: begin
        if (dec_op == OP_MOVE2) begin
          next_state = ST_MOVE_DST;
        end else if (dec_op == OP_MOVE3) begin
          next_state = ST_LONG_MID;
        end else if (unit_skip) begin
          next_state = ST_SKIP;
        end else begin
          next_state = ST_DECODE;
        end
      end
      ST_MOVE_DST: next_state = ST_DECODE;
      ST_LONG_MID: next_state = ST_LONG_DST;
      ST_LONG_DST: next_state = ST_DECODE;
      ST_SKIP: begin
        next_tail = skipped_tail;
        next_state = (skipped_tail == 2'h0) ? ST_DECODE : ST_SKIP_TAIL;
      end
      ST_SKIP_TAIL: begin
        next_tail = tail - 2'h1;
        next_state = (tail == 2'h1) ? ST_DECODE : ST_SKIP_TAIL;
      end
      default: next_state = ST_DECODE;
    endcase
  end

  // End of instruction and its cycle count
  wire instr_end = (next_state == ST_DECODE);
  wire [2:0] next_cyc = instr_end ? 3'h0 : cyc + 3'h1;
  wire [2:0] cyc_total = cyc + CYCLES_ONE;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= ST_DECODE;
      tail <= 2'h0;
      cyc <= 3'h0;
    end else if (boundary) begin
      state <= next_state;
      tail <= next_tail;
      cyc <= next_cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output next values
  wire op_t next_op = in_decode ? dec_op : (in_skip ? OP_NOP : OP);
  wire [4:0] next_flags = in_decode ? flag_mask(dec_op) : FLAGS_NONE;
  wire [ADDR_W-1:0] next_file_addr = in_decode ? {sel_bank, f_field} : FILE_ADDR;
  wire next_dest = in_decode && dec_dest;
  wire [2:0] next_bit = in_decode ? b_field : BIT_NUM;
  wire [7:0] next_result = in_decode ? unit_result : RESULT;
  wire next_nop = in_skip || (in_decode && dec_op == OP_NOP);

  // Source address: short move forced to the low 4k, long move in two parts
  wire [ADDR_W-1:0] next_src =
    (in_decode && dec_op == OP_MOVE2) ? {MOVE_FORCED_BANK, INSTR_WORD[11:0]} :
    (in_decode && dec_op == OP_MOVE3) ? {INSTR_WORD[3:0], 10'h000} :
    (state == ST_LONG_MID) ? {SRC_ADDR[13:10], INSTR_WORD[11:2]} : SRC_ADDR;
  wire [ADDR_W-1:0] next_dst =
    (state == ST_MOVE_DST) ? {MOVE_FORCED_BANK, INSTR_WORD[11:0]} :
    (state == ST_LONG_MID) ? {INSTR_WORD[1:0], 12'h000} :
    (state == ST_LONG_DST) ? {DST_ADDR[13:12], INSTR_WORD[11:0]} : DST_ADDR;
  wire next_move = (state == ST_MOVE_DST) || (state == ST_LONG_DST);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      OP <= OP_NOP;
      FLAG_MASK <= FLAGS_NONE;
      FILE_ADDR <= '0;
      DEST_TO_FILE <= 1'b0;
      BIT_NUM <= 3'h0;
      RESULT <= 8'h00;
      EXEC_NOP <= 1'b0;
      SKIP_TAKEN <= 1'b0;
    end else if (boundary) begin
      OP <= next_op;
      FLAG_MASK <= next_flags;
      FILE_ADDR <= next_file_addr;
      DEST_TO_FILE <= next_dest;
      BIT_NUM <= next_bit;
      RESULT <= next_result;
      EXEC_NOP <= next_nop;
      SKIP_TAKEN <= take_skip;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SRC_ADDR <= '0;
      DST_ADDR <= '0;
      MOVE_VALID <= 1'b0;
      INSTR_DONE <= 1'b0;
      INSTR_CYCLES <= 3'h0;
    end else if (boundary) begin
      SRC_ADDR <= next_src;
      DST_ADDR <= next_dst;
      MOVE_VALID <= next_move;
      INSTR_DONE <= instr_end;
      INSTR_CYCLES <= cyc_total;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  wire [7:0] swapped_in = {FILE_DATA[3:0], FILE_DATA[7:4]};

  cycle_length_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE |=> !CYCLE_STROBE [*3] ##1 CYCLE_STROBE)
    else $error("instruction cycle is not four clocks");

  arith_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_ADD_W, OP_ADD_C, OP_INC, OP_DEC, OP_NEG,
      OP_SUB_FW, OP_SUB_FW_B, OP_SUB_WF_B} |-> FLAG_MASK == FLAGS_ARITH && !EXEC_NOP)
    else $error("arithmetic op does not update all flags");

  logic_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_AND, OP_IOR, OP_XOR, OP_COM, OP_COPY, OP_RL_N, OP_RR_N}
      |-> FLAG_MASK == FLAGS_ZN)
    else $error("logic op flag set wrong");

  quiet_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_SET, OP_STORE_W, OP_MUL_W, OP_SWAP, OP_MOVE2, OP_MOVE3}
      |-> FLAG_MASK == FLAGS_NONE)
    else $error("flagless op updates flags");

  carry_rotate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_RL_C, OP_RR_C} |-> FLAG_MASK == FLAGS_CZN
      && (OP == OP_RR_C ? RESULT[7] : RESULT[0]) == $past(CARRY_IN))
    else $error("rotate through carry wrong");

  bit_ops_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_BIT_CLR, OP_BIT_SET, OP_BIT_TOG} |-> FLAG_MASK == FLAGS_NONE
      && DEST_TO_FILE && INSTR_DONE && INSTR_CYCLES == CYCLES_ONE)
    else $error("bit op not flagless single cycle");

  skip_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP inside {OP_CP_EQ, OP_CP_GT, OP_CP_LT, OP_DEC_SZ, OP_DEC_SNZ, OP_INC_SZ, OP_INC_SNZ,
      OP_TST_SZ, OP_BIT_SKC, OP_BIT_SKS} |-> FLAG_MASK == FLAGS_NONE && INSTR_DONE == !SKIP_TAKEN)
    else $error("skip op flags or length wrong");

  move_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && MOVE_VALID |-> FLAG_MASK == FLAGS_NONE && !DEST_TO_FILE && !SKIP_TAKEN)
    else $error("move touches flags");

  skip_tail_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && EXEC_NOP && !INSTR_DONE |-> OP == OP_NOP && FLAG_MASK == FLAGS_NONE && !SKIP_TAKEN)
    else $error("skipped word not a no-operation");

  swap_result_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && OP == OP_SWAP && !EXEC_NOP |-> RESULT == $past(swapped_in))
    else $error("nibble swap wrong");

  move_bank_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    MOVE_VALID && OP == OP_MOVE2 |-> SRC_ADDR[13:12] == MOVE_FORCED_BANK
      && DST_ADDR[13:12] == MOVE_FORCED_BANK)
    else $error("short move reaches above 4k");

  move_cycles_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && MOVE_VALID && OP == OP_MOVE2 |-> INSTR_DONE && INSTR_CYCLES == 3'h2)
    else $error("short move not two cycles");

  long_cycles_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && MOVE_VALID && OP == OP_MOVE3 |-> INSTR_DONE && INSTR_CYCLES == 3'h3)
    else $error("long move not three cycles");

  skip_nop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CYCLE_STROBE && SKIP_TAKEN |-> !INSTR_DONE ##4 (EXEC_NOP && OP == OP_NOP))
    else $error("taken skip not followed by no-operation");

  trailing_nop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    boundary && in_decode && INSTR_WORD[15:12] == TRAIL_PREFIX |=> EXEC_NOP && FLAG_MASK == FLAGS_NONE)
    else $error("lone trailing word not a no-operation");

  dest_steer_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    boundary && in_decode && has_dest(dec_op) |=> DEST_TO_FILE == $past(d_bit))
    else $error("destination bit not followed");

  access_bank_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    boundary && in_decode && a_bit |=> FILE_ADDR[13:8] == $past(BANK_SEL))
    else $error("banked access ignores bank register");

endmodule

// *** hw/decode_pkg.sv ***
/*
  Shared constants, types and decode functions for the file-register instruction decoder.
  Assumes 16-bit instruction words and a 14-bit data address space.
*/
package decode_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing and address layout
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(PHASES_PER_CYCLE - 1);
  localparam int ADDR_W = 14;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [5:0] ACCESS_LOW_BANK = 6'h00;
  localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3f;
  localparam logic [1:0] MOVE_FORCED_BANK = 2'h0;
  localparam logic [3:0] TRAIL_PREFIX = 4'hf;
  localparam logic [11:0] LONG_MOVE_HEAD = 12'h006;
  localparam logic [2:0] CYCLES_ONE = 3'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Word fields
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITNUM_LSB = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag mask bits and groups
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_HC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  localparam int FLAG_N_BIT = 4;
  localparam logic [4:0] FLAGS_NONE = 5'h00;
  localparam logic [4:0] FLAGS_ARITH = 5'h1f;
  localparam logic [4:0] FLAGS_ZN = 5'h14;
  localparam logic [4:0] FLAGS_Z = 5'h04;
  localparam logic [4:0] FLAGS_CZN = 5'h15;

  typedef enum logic [5:0] {
    OP_NOP, OP_OTHER, OP_ADD_W, OP_ADD_C, OP_AND, OP_IOR, OP_XOR, OP_COM,
    OP_CLR, OP_DEC, OP_INC, OP_COPY, OP_STORE_W, OP_MUL_W, OP_NEG, OP_SET,
    OP_RL_C, OP_RL_N, OP_RR_C, OP_RR_N, OP_SUB_FW, OP_SUB_FW_B, OP_SUB_WF_B,
    OP_SWAP, OP_CP_EQ, OP_CP_GT, OP_CP_LT, OP_DEC_SZ, OP_DEC_SNZ, OP_INC_SZ,
    OP_INC_SNZ, OP_TST_SZ, OP_BIT_CLR, OP_BIT_SET, OP_BIT_TOG, OP_BIT_SKC,
    OP_BIT_SKS, OP_MOVE2, OP_MOVE3
  } op_t;

  typedef enum logic [2:0] {
    ST_DECODE, ST_MOVE_DST, ST_LONG_MID, ST_LONG_DST, ST_SKIP, ST_SKIP_TAIL
  } st_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Opcode decode of a first word
  function automatic op_t decode_op(input logic [15:0] w);
    op_t op;
    op = OP_OTHER;
    casez (w[15:8])
      8'b0010_01??: op = OP_ADD_W;
      8'b0010_00??: op = OP_ADD_C;
      8'b0010_10??: op = OP_INC;
      8'b0010_11??: op = OP_DEC_SZ;
      8'b0000_01??: op = OP_DEC;
      8'b0000_001?: op = OP_MUL_W;
      8'b0001_00??: op = OP_IOR;
      8'b0001_01??: op = OP_AND;
      8'b0001_10??: op = OP_XOR;
      8'b0001_11??: op = OP_COM;
      8'b0011_00??: op = OP_RR_C;
      8'b0011_01??: op = OP_RL_C;
      8'b0011_10??: op = OP_SWAP;
      8'b0011_11??: op = OP_INC_SZ;
      8'b0100_00??: op = OP_RR_N;
      8'b0100_01??: op = OP_RL_N;
      8'b0100_10??: op = OP_INC_SNZ;
      8'b0100_11??: op = OP_DEC_SNZ;
      8'b0101_00??: op = OP_COPY;
      8'b0101_01??: op = OP_SUB_WF_B;
      8'b0101_10??: op = OP_SUB_FW_B;
      8'b0101_11??: op = OP_SUB_FW;
      8'b0110_000?: op = OP_CP_LT;
      8'b0110_001?: op = OP_CP_EQ;
      8'b0110_010?: op = OP_CP_GT;
      8'b0110_011?: op = OP_TST_SZ;
      8'b0110_100?: op = OP_SET;
      8'b0110_101?: op = OP_CLR;
      8'b0110_110?: op = OP_NEG;
      8'b0110_111?: op = OP_STORE_W;
      8'b0111_????: op = OP_BIT_TOG;
      8'b1000_????: op = OP_BIT_SET;
      8'b1001_????: op = OP_BIT_CLR;
      8'b1010_????: op = OP_BIT_SKS;
      8'b1011_????: op = OP_BIT_SKC;
      8'b1100_????: op = OP_MOVE2;
      8'b1111_????: op = OP_NOP;
      default: op = OP_OTHER;
    endcase
    if (w[15:4] == LONG_MOVE_HEAD) begin
      op = OP_MOVE3;
    end
    return op;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Flags each operation may update
  function automatic logic [4:0] flag_mask(input op_t op);
    logic [4:0] m;
    m = FLAGS_NONE;
    case (op)
      OP_ADD_W, OP_ADD_C, OP_INC, OP_DEC, OP_NEG,
      OP_SUB_FW, OP_SUB_FW_B, OP_SUB_WF_B: m = FLAGS_ARITH;
      OP_AND, OP_IOR, OP_XOR, OP_COM, OP_COPY,
      OP_RL_N, OP_RR_N: m = FLAGS_ZN;
      OP_RL_C, OP_RR_C: m = FLAGS_CZN;
      OP_CLR: m = FLAGS_Z;
      default: m = FLAGS_NONE;
    endcase
    return m;
  endfunction

  // Operations whose word carries a destination bit
  function automatic logic has_dest(input op_t op);
    logic r;
    r = 1'b0;
    case (op)
      OP_ADD_W, OP_ADD_C, OP_INC, OP_DEC, OP_AND, OP_IOR, OP_XOR, OP_COM,
      OP_COPY, OP_RL_C, OP_RL_N, OP_RR_C, OP_RR_N, OP_SUB_FW, OP_SUB_FW_B,
      OP_SUB_WF_B, OP_SWAP, OP_DEC_SZ, OP_DEC_SNZ, OP_INC_SZ, OP_INC_SNZ: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Operations that always write the file register
  function automatic logic writes_file(input op_t op);
    logic r;
    r = 1'b0;
    case (op)
      OP_CLR, OP_SET, OP_NEG, OP_STORE_W,
      OP_BIT_CLR, OP_BIT_SET, OP_BIT_TOG: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// *** hw/operand_unit.sv ***
/*
  Combinational result and skip condition for one decoded file-register operation.
  Assumes operands are stable while the decoder samples them.
*/
`timescale 1ns/1ps
module operand_unit import decode_pkg::*; (
  // Operation
  input wire op_t op,
  input wire logic [2:0] bit_num,
  // Operands
  input wire logic [7:0] file_data,
  input wire logic [7:0] work_data,
  input wire logic carry_in,
  // Answer
  output logic [7:0] result,
  output logic take_skip
);

  wire [7:0] inc_val = file_data + 8'h01;
  wire [7:0] dec_val = file_data - 8'h01;
  wire [7:0] bit_mask = 8'h01 << bit_num;
  wire bit_val = |(file_data & bit_mask);

  always_comb begin
    case (op)
      OP_INC, OP_INC_SZ, OP_INC_SNZ: result = inc_val;
      OP_DEC, OP_DEC_SZ, OP_DEC_SNZ: result = dec_val;
      OP_RL_C: result = {file_data[6:0], carry_in};
      OP_RR_C: result = {carry_in, file_data[7:1]};
      OP_RL_N: result = {file_data[6:0], file_data[7]};
      OP_RR_N: result = {file_data[0], file_data[7:1]};
      OP_SWAP: result = {file_data[3:0], file_data[7:4]};
      OP_COM: result = ~file_data;
      OP_CLR: result = 8'h00;
      OP_SET: result = 8'hff;
      OP_BIT_CLR: result = file_data & ~bit_mask;
      OP_BIT_SET: result = file_data | bit_mask;
      OP_BIT_TOG: result = file_data ^ bit_mask;
      OP_STORE_W: result = work_data;
      default: result = file_data;
    endcase
  end

  always_comb begin
    case (op)
      OP_CP_EQ: take_skip = file_data == work_data;
      OP_CP_GT: take_skip = file_data > work_data;
      OP_CP_LT: take_skip = file_data < work_data;
      OP_DEC_SZ: take_skip = dec_val == 8'h00;
      OP_TST_SZ: take_skip = file_data == 8'h00;
      OP_DEC_SNZ: take_skip = dec_val != 8'h00;
      OP_INC_SNZ: take_skip = inc_val != 8'h00;
      OP_INC_SZ: take_skip = inc_val == 8'h00;
      OP_BIT_SKC: take_skip = !bit_val;
      OP_BIT_SKS: take_skip = bit_val;
      default: take_skip = 1'b0;
    endcase
  end

endmodule

// *** tb/prog_mem_model.sv ***
/*
  Program memory model: presents one fetched word and its operand bytes per instruction cycle.
  Assumes the bench fills the arrays while reset is held, and that the decoder pulses strobe once a cycle.
*/
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  // Fetched word and operands
  output logic [15:0] word,
  output logic [7:0] file_byte,
  output logic [7:0] work_byte
);
  logic [15:0] mem [32];
  logic [7:0] fmem [32];
  logic [7:0] wmem [32];
  logic [4:0] pc;

  ////////////////////////////////////////////////////////////////////////////////
  // Advance one word per instruction cycle, after the strobe clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= 5'h00;
    end else if (strobe) begin
      pc <= pc + 5'h01;
    end
  end

  assign word = mem[pc];
  assign file_byte = fmem[pc];
  assign work_byte = wmem[pc];
endmodule

// *** tb/tb.sv ***
/*
  Self-checking bench for the file-register instruction decoder.
  Assumes the program memory model feeds words; carry and bank select are driven here.
*/
`timescale 1ns/1ps
module tb import decode_pkg::*; ;
  logic ref_clk, rst_n, carry, strobe, to_file, mv, nop, skip, done;
  logic [5:0] bank;
  logic [15:0] word;
  logic [7:0] fb, wb, res;
  op_t op;
  logic [ADDR_W-1:0] faddr, src, dst;
  logic [2:0] bnum, cyc;
  logic [4:0] fm;
  int n_errors = 0;
  int cmp_count = 0;

  prog_mem_model prog_mem_model_inst (.clk(ref_clk), .rst_n(rst_n), .strobe(strobe), .word(word),
    .file_byte(fb), .work_byte(wb));

  file_register_instr_decoder file_register_instr_decoder_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
    .INSTR_WORD(word), .FILE_DATA(fb), .WORK_DATA(wb), .CARRY_IN(carry), .BANK_SEL(bank),
    .CYCLE_STROBE(strobe), .OP(op), .FILE_ADDR(faddr), .DEST_TO_FILE(to_file), .BIT_NUM(bnum),
    .FLAG_MASK(fm), .RESULT(res), .SRC_ADDR(src), .DST_ADDR(dst), .MOVE_VALID(mv),
    .EXEC_NOP(nop), .SKIP_TAKEN(skip), .INSTR_DONE(done), .INSTR_CYCLES(cyc));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic next_cycle();
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (strobe === 1'b1) break;
    end
    if (i == 8) begin
      n_errors++;
      $display("unexpected strobe expected 1 seen 0");
      wrap_up();
    end
  endtask

  task automatic step(input op_t o, input logic [4:0] m, input logic d, input logic [2:0] c);
    next_cycle();
    chk("op", 16'(o), 16'(op));
    chk("flag mask", 16'(m), 16'(fm));
    chk("done", 16'(d), 16'(done));
    if (d) begin
      chk("cycles", 16'(c), 16'(cyc));
    end
  endtask

  task automatic put(input int i, input logic [15:0] w, input logic [7:0] f, input logic [7:0] v);
    prog_mem_model_inst.mem[i] = w;
    prog_mem_model_inst.fmem[i] = f;
    prog_mem_model_inst.wmem[i] = v;
  endtask

  task automatic blank(input logic c, input logic [5:0] b);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    carry <= c;
    bank <= b;
    for (int i = 0; i < 32; i++) begin
      put(i, 16'hf000, 8'h00, 8'h00);
    end
  endtask

  task automatic go();
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_flags();
    logic [15:0] w [23] = '{16'h2600, 16'h2000, 16'h2800, 16'h0400, 16'h1400, 16'h1000, 16'h1c00,
      16'h1800, 16'h6c00, 16'h6a00, 16'h6800, 16'h6e00, 16'h0200, 16'h5c00, 16'h5800, 16'h5400,
      16'h3400, 16'h4400, 16'h4000, 16'h3000, 16'h5000, 16'h3800, 16'h0e55};
    op_t o [23] = '{OP_ADD_W, OP_ADD_C, OP_INC, OP_DEC, OP_AND, OP_IOR, OP_COM, OP_XOR, OP_NEG,
      OP_CLR, OP_SET, OP_STORE_W, OP_MUL_W, OP_SUB_FW, OP_SUB_FW_B, OP_SUB_WF_B, OP_RL_C, OP_RL_N,
      OP_RR_N, OP_RR_C, OP_COPY, OP_SWAP, OP_OTHER};
    logic [4:0] m [23] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h14, 5'h14, 5'h14, 5'h14, 5'h1f, 5'h04,
      5'h00, 5'h00, 5'h00, 5'h1f, 5'h1f, 5'h1f, 5'h15, 5'h14, 5'h14, 5'h15, 5'h14, 5'h00, 5'h00};
    blank(1'b0, 6'h00);
    for (int i = 0; i < 23; i++) begin
      put(i, w[i], 8'h10, 8'h20);
    end
    go();
    for (int i = 0; i < 23; i++) begin
      step(o[i], m[i], 1'b1, 3'h1);
    end
    $display("test flags done");
  endtask

  task automatic t_fields();
    blank(1'b1, 6'h05);
    put(0, 16'h2670, 8'h00, 8'h00);
    put(1, 16'h2145, 8'h00, 8'h00);
    put(2, 16'h9b12, 8'hff, 8'h00);
    put(3, 16'h3800, 8'h3c, 8'h00);
    put(4, 16'h3000, 8'h81, 8'h00);
    put(5, 16'h7400, 8'h00, 8'h00);
    put(6, 16'h8600, 8'h00, 8'h00);
    go();
    step(OP_ADD_W, 5'h1f, 1'b1, 3'h1);
    chk("file addr", 16'h3f70, 16'(faddr));
    chk("dest", 16'h0001, 16'(to_file));
    step(OP_ADD_C, 5'h1f, 1'b1, 3'h1);
    chk("file addr", 16'h0545, 16'(faddr));
    chk("dest", 16'h0000, 16'(to_file));
    step(OP_BIT_CLR, 5'h00, 1'b1, 3'h1);
    chk("bit num", 16'h0005, 16'(bnum));
    chk("result", 16'h00df, 16'(res));
    step(OP_SWAP, 5'h00, 1'b1, 3'h1);
    chk("result", 16'h00c3, 16'(res));
    step(OP_RR_C, 5'h15, 1'b1, 3'h1);
    chk("result", 16'h00c0, 16'(res));
    step(OP_BIT_TOG, 5'h00, 1'b1, 3'h1);
    chk("result", 16'h0004, 16'(res));
    step(OP_BIT_SET, 5'h00, 1'b1, 3'h1);
    chk("bit num", 16'h0003, 16'(bnum));
    chk("result", 16'h0008, 16'(res));
    $display("test fields done");
  endtask

  task automatic t_moves();
    blank(1'b0, 6'h2a);
    put(0, 16'hc923, 8'h00, 8'h00);
    put(1, 16'hfa56, 8'h00, 8'h00);
    put(2, 16'h0063, 8'h00, 8'h00);
    put(3, 16'hfaae, 8'h00, 8'h00);
    put(4, 16'hf123, 8'h00, 8'h00);
    put(5, 16'hf777, 8'h00, 8'h00);
    go();
    step(OP_MOVE2, 5'h00, 1'b0, 3'h0);
    next_cycle();
    chk("move valid", 16'h0001, 16'(mv));
    chk("src", 16'h0923, 16'(src));
    chk("dst", 16'h0a56, 16'(dst));
    chk("cycles", 16'h0002, 16'(cyc));
    step(OP_MOVE3, 5'h00, 1'b0, 3'h0);
    next_cycle();
    chk("done", 16'h0000, 16'(done));
    next_cycle();
    chk("move valid", 16'h0001, 16'(mv));
    chk("src", 16'h0eab, 16'(src));
    chk("dst", 16'h2123, 16'(dst));
    chk("cycles", 16'h0003, 16'(cyc));
    step(OP_NOP, 5'h00, 1'b1, 3'h1);
    $display("test moves done");
  endtask

  task automatic skp(input op_t o);
    step(o, 5'h00, 1'b0, 3'h0);
    chk("skip", 16'h0001, 16'(skip));
    step(OP_NOP, 5'h00, 1'b1, 3'h2);
    chk("nop", 16'h0001, 16'(nop));
  endtask

  task automatic t_skips();
    blank(1'b0, 6'h00);
    put(0, 16'h6200, 8'h05, 8'h05);
    put(1, 16'h2600, 8'h00, 8'h00);
    put(2, 16'h6200, 8'h05, 8'h06);
    put(3, 16'h6400, 8'h07, 8'h06);
    put(4, 16'hc000, 8'h00, 8'h00);
    put(6, 16'h2c00, 8'h01, 8'h00);
    put(8, 16'ha200, 8'h02, 8'h00);
    put(10, 16'ha200, 8'hfd, 8'h00);
    put(11, 16'h6000, 8'h01, 8'h02);
    put(13, 16'h6600, 8'h00, 8'h00);
    put(15, 16'h4800, 8'h00, 8'h00);
    put(17, 16'h3c00, 8'hff, 8'h00);
    put(19, 16'h4c00, 8'h02, 8'h00);
    put(21, 16'hb000, 8'hfe, 8'h00);
    put(23, 16'h6200, 8'h05, 8'h05);
    put(24, 16'h0061, 8'h00, 8'h00);
    go();
    skp(OP_CP_EQ);
    step(OP_CP_EQ, 5'h00, 1'b1, 3'h1);
    chk("skip", 16'h0000, 16'(skip));
    step(OP_CP_GT, 5'h00, 1'b0, 3'h0);
    step(OP_NOP, 5'h00, 1'b0, 3'h0);
    step(OP_NOP, 5'h00, 1'b1, 3'h3);
    skp(OP_DEC_SZ);
    skp(OP_BIT_SKS);
    step(OP_BIT_SKS, 5'h00, 1'b1, 3'h1);
    skp(OP_CP_LT);
    skp(OP_TST_SZ);
    skp(OP_INC_SNZ);
    skp(OP_INC_SZ);
    skp(OP_DEC_SNZ);
    skp(OP_BIT_SKC);
    step(OP_CP_EQ, 5'h00, 1'b0, 3'h0);
    step(OP_NOP, 5'h00, 1'b0, 3'h0);
    step(OP_NOP, 5'h00, 1'b0, 3'h0);
    step(OP_NOP, 5'h00, 1'b1, 3'h4);
    $display("test skips done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    carry = 1'b0;
    bank = 6'h00;
    t_flags();
    t_fields();
    t_moves();
    t_skips();
    wrap_up();
  end
endmodule
